// ---- design/ioc_index_io.sv ----
// Summary of operation
// - Encoder style setting ignored; always line drive.
// - Start index parameter 0-63 picks start index.
// - Value 64 takes start index from pins.
// - Select pins form binary index, pin0 LSB.
// - Buffer mode 0 keeps two starts, 1 one.
// - Index outputs show running or previous index.
// - Start edges: rising only, or both edges.
// - Jog by go/direction or separate forward/reverse.
// - Velocity override at index boundaries or real-time.
// - Registration mode from index type or config.
// - Software limit during jog only when enabled.
// - Registration config 0-1 governs trigger handling.
// - Config 0 relative target, 1 absolute.
`timescale 1ns/1ps
module ioc_index_io
   import ioc_pkg::*;
#(
   parameter int IDX_W = 6,
   parameter int OVR_W = 8
)(
   // APB slave
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Index start and selection
   input  wire logic              start_in,
   input  wire logic [IDX_W-1:0]  index_select_inputs,
   input  wire logic              index_done_in,
   output logic                   start_pulse_o,
   output logic      [IDX_W-1:0]  start_index_o,
   output logic      [IDX_W-1:0]  index_number_outputs,
   // Jog
   input  wire ioc_jog_in_t       jog_in,
   output logic                   jog_fwd_o,
   output logic                   jog_rev_o,
   output logic                   soft_limit_en_o,
   // Velocity override
   input  wire logic [OVR_W-1:0]  vel_override_in,
   output logic      [OVR_W-1:0]  vel_override_o,
   // Registration
   input  wire logic              registration_trigger,
   input  wire logic              index_reg_absolute_in,
   output logic                   reg_capture_o,
   output logic                   reg_absolute_o,
   // Homing and encoder
   input  wire ioc_home_in_t      home_in,
   output logic                   origin_reached_output,
   output logic                   encoder_line_drive_o
);

   // ------------------------------------------------------------
   // Registers and state
   // ------------------------------------------------------------
   logic [15:0]      enc_style_r;
   logic [15:0]      start_sel_r;
   logic [15:0]      start_buf_r;
   logic [15:0]      io_behav_r;
   logic [15:0]      reg_cfg_r;
   logic [IDX_W-1:0] q0_r;
   logic [IDX_W-1:0] q1_r;
   logic [1:0]       count_r;
   logic             busy_r;
   logic [IDX_W-1:0] running_r;
   logic [IDX_W-1:0] completed_r;
   logic             start_prev_r;
   logic             trig_prev_r;
   logic [31:0]      rd_nxt;
   logic             err_nxt;
   logic             wr_en;
   logic             start_edge;
   logic [IDX_W-1:0] new_index;
   logic [1:0]       depth;
   logic             push;
   logic             pop;
   logic             jog_active;

   // ------------------------------------------------------------
   // APB access
   // ------------------------------------------------------------
   // Zero-wait access: pready rises for the access phase of each transfer
   assign wr_en = psel && penable && pready && pwrite;

   always_comb
   begin
      rd_nxt  = 32'h0000_0000;
      err_nxt = 1'b0;
      case (paddr)
         ADDR_ENC_STYLE: rd_nxt = {16'h0000, enc_style_r};
         ADDR_START_SEL: rd_nxt = {16'h0000, start_sel_r};
         ADDR_START_BUF: rd_nxt = {16'h0000, start_buf_r};
         ADDR_IO_BEHAV:  rd_nxt = {16'h0000, io_behav_r};
         ADDR_REG_CFG:   rd_nxt = {16'h0000, reg_cfg_r};
         ADDR_STATUS:
         begin
            rd_nxt  = 32'h0000_0000;
            rd_nxt[IDX_W-1:0]         = completed_r;
            rd_nxt[2*IDX_W-1:IDX_W]   = running_r;
            rd_nxt[2*IDX_W+1:2*IDX_W] = count_r;
            rd_nxt[2*IDX_W+2]         = busy_r;
            err_nxt = pwrite;
         end
         default: err_nxt = 1'b1;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= psel && !penable && !pready;
         prdata  <= (psel && !penable && !pwrite) ? rd_nxt : 32'h0000_0000;
         pslverr <= psel && !penable && err_nxt;
      end
   end

   // Unmapped and status writes are refused and leave all state alone
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         enc_style_r <= RST_ENC_STYLE;
         start_sel_r <= RST_START_SEL;
         start_buf_r <= RST_START_BUF;
         io_behav_r  <= RST_IO_BEHAV;
         reg_cfg_r   <= RST_REG_CFG;
      end
      else if (wr_en)
      begin
         case (paddr)
            ADDR_ENC_STYLE: enc_style_r <= pwdata[15:0];
            ADDR_START_SEL: start_sel_r <= pwdata[15:0];
            ADDR_START_BUF: start_buf_r <= pwdata[15:0];
            ADDR_IO_BEHAV:  io_behav_r  <= pwdata[15:0];
            ADDR_REG_CFG:   reg_cfg_r   <= pwdata[15:0];
            default:        ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Encoder output style
   // ------------------------------------------------------------
   // The stored style is readable but never steers the encoder driver
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         encoder_line_drive_o <= 1'b1;
      else
         encoder_line_drive_o <= 1'b1;
   end

   // ------------------------------------------------------------
   // Start edge detection and index choice
   // ------------------------------------------------------------
   assign start_edge = (start_in && !start_prev_r) ||
                       (io_behav_r[IOB_BOTH_EDGES] && !start_in && start_prev_r);

   // Values above 64 are treated like 64: pins decide
   assign new_index = (start_sel_r < START_SEL_PINS) ?
                      start_sel_r[IDX_W-1:0] :
                      index_select_inputs;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         start_prev_r <= 1'b0;
         trig_prev_r  <= 1'b0;
      end
      else
      begin
         start_prev_r <= start_in;
         trig_prev_r  <= registration_trigger;
      end
   end

   // ------------------------------------------------------------
   // Start command queue
   // ------------------------------------------------------------
   assign depth = (start_buf_r == 16'h0000) ? DEPTH_DOUBLE : DEPTH_SINGLE;
   // Full check is made before the pop, so a start meeting a full queue drops
   assign push  = start_edge && (count_r < depth);
   assign pop   = (count_r != 2'h0) && !busy_r;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         q0_r    <= '0;
         q1_r    <= '0;
         count_r <= 2'h0;
      end
      else
      begin
         case ({push, pop})
            2'b10:
            begin
               if (count_r == 2'h0)
                  q0_r <= new_index;
               else
                  q1_r <= new_index;
               count_r <= count_r + 2'h1;
            end
            2'b01:
            begin
               q0_r    <= q1_r;
               count_r <= count_r - 2'h1;
            end
            2'b11:
            begin
               if (count_r == 2'h1)
                  q0_r <= new_index;
               else
               begin
                  q0_r <= q1_r;
                  q1_r <= new_index;
               end
            end
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Index issue and progress
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         busy_r        <= 1'b0;
         start_pulse_o <= 1'b0;
         start_index_o <= '0;
         running_r     <= '0;
         completed_r   <= '0;
      end
      else
      begin
         start_pulse_o <= pop;
         if (pop)
         begin
            busy_r        <= 1'b1;
            start_index_o <= q0_r;
            running_r     <= q0_r;
         end
         else if (busy_r && index_done_in)
         begin
            busy_r      <= 1'b0;
            completed_r <= running_r;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         index_number_outputs <= '0;
      else if (busy_r && !io_behav_r[IOB_SHOW_PREV])
         index_number_outputs <= running_r;
      else
         index_number_outputs <= completed_r;
   end

   // ------------------------------------------------------------
   // Jog and software limit
   // ------------------------------------------------------------
   // Opposing split inputs cancel rather than pick a winner
   assign jog_active = io_behav_r[IOB_SPLIT_JOG] ? (jog_in.fwd ^ jog_in.rev) : jog_in.go;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         jog_fwd_o       <= 1'b0;
         jog_rev_o       <= 1'b0;
         soft_limit_en_o <= 1'b1;
      end
      else
      begin
         if (io_behav_r[IOB_SPLIT_JOG])
         begin
            jog_fwd_o <= jog_in.fwd && !jog_in.rev;
            jog_rev_o <= jog_in.rev && !jog_in.fwd;
         end
         else
         begin
            jog_fwd_o <= jog_in.go && !jog_in.dir;
            jog_rev_o <= jog_in.go && jog_in.dir;
         end
         soft_limit_en_o <= !jog_active || io_behav_r[IOB_JOG_LIMIT];
      end
   end

   // ------------------------------------------------------------
   // Velocity override
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         vel_override_o <= '0;
      else if (io_behav_r[IOB_OVR_RT] || pop)
         vel_override_o <= vel_override_in;
   end

   // ------------------------------------------------------------
   // Registration
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         reg_capture_o  <= 1'b0;
         reg_absolute_o <= 1'b0;
      end
      else
      begin
         reg_capture_o <= registration_trigger && !trig_prev_r;
         if (io_behav_r[IOB_REG_BY_CFG])
            reg_absolute_o <= reg_cfg_r[0];
         else
            reg_absolute_o <= index_reg_absolute_in;
      end
   end

   // ------------------------------------------------------------
   // Origin output
   // ------------------------------------------------------------
   // Homing completion wins over a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         origin_reached_output <= 1'b0;
      else if (home_in.homing_done)
         origin_reached_output <= 1'b1;
      else if (home_in.homing_start ||
               (io_behav_r[IOB_ORG_DROP] && !home_in.servo_on))
         origin_reached_output <= 1'b0;
   end

endmodule : ioc_index_io

// ---- design/ioc_pkg.sv ----
package ioc_pkg;

   // ------------------------------------------------------------
   // Register indices and byte addresses
   // ------------------------------------------------------------
   localparam int          ADDR_W          = 16;
   localparam logic [15:0] IDX_ENC_STYLE   = 16'h3007;
   localparam logic [15:0] IDX_START_SEL   = 16'h3008;
   localparam logic [15:0] IDX_START_BUF   = 16'h3009;
   localparam logic [15:0] IDX_IO_BEHAV    = 16'h300A;
   localparam logic [15:0] IDX_REG_CFG     = 16'h300B;
   localparam logic [15:0] IDX_STATUS      = 16'h3020;
   localparam logic [15:0] ADDR_ENC_STYLE  = 16'(IDX_ENC_STYLE * 4);
   localparam logic [15:0] ADDR_START_SEL  = 16'(IDX_START_SEL * 4);
   localparam logic [15:0] ADDR_START_BUF  = 16'(IDX_START_BUF * 4);
   localparam logic [15:0] ADDR_IO_BEHAV   = 16'(IDX_IO_BEHAV * 4);
   localparam logic [15:0] ADDR_REG_CFG    = 16'(IDX_REG_CFG * 4);
   localparam logic [15:0] ADDR_STATUS     = 16'(IDX_STATUS * 4);

   // ------------------------------------------------------------
   // Reset values and field positions
   // ------------------------------------------------------------
   localparam logic [15:0] RST_ENC_STYLE   = 16'h0000;
   localparam logic [15:0] RST_START_SEL   = 16'h0000;
   localparam logic [15:0] RST_START_BUF   = 16'h0001;
   localparam logic [15:0] RST_IO_BEHAV    = 16'h0000;
   localparam logic [15:0] RST_REG_CFG     = 16'h0000;
   localparam logic [15:0] START_SEL_PINS  = 16'h0040;
   localparam int          IOB_SHOW_PREV   = 0;
   localparam int          IOB_BOTH_EDGES  = 1;
   localparam int          IOB_SPLIT_JOG   = 2;
   localparam int          IOB_OVR_RT      = 3;
   localparam int          IOB_REG_BY_CFG  = 4;
   localparam int          IOB_JOG_LIMIT   = 5;
   localparam int          IOB_ORG_DROP    = 6;
   localparam logic [1:0]  DEPTH_DOUBLE    = 2'h2;
   localparam logic [1:0]  DEPTH_SINGLE    = 2'h1;

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic go;
      logic dir;
      logic fwd;
      logic rev;
   } ioc_jog_in_t;

   typedef struct packed {
      logic homing_start;
      logic homing_done;
      logic servo_on;
   } ioc_home_in_t;

endpackage : ioc_pkg

// ---- sim/ioc_ctrl_model.sv ----
`timescale 1ns/1ps
module ioc_ctrl_model (
   // Clock
   input  wire logic pclk,
   // Digital inputs of the drive
   output logic       start_in,
   output logic [5:0] index_select_inputs
);
   initial
   begin
      start_in = 1'b0;
      index_select_inputs = 6'h00;
   end

   // Every level change is a command in both-edge mode, rising only otherwise; gap models a slow controller
   task automatic toggle(input int gap);
      repeat (gap) @(posedge pclk);
      @(posedge pclk);
      start_in <= ~start_in;
   endtask : toggle

   task automatic pick(input logic [5:0] idx);
      @(posedge pclk);
      index_select_inputs <= idx;
   endtask : pick
endmodule : ioc_ctrl_model

// ---- sim/ioc_index_io_asserts.sv ----
`timescale 1ns/1ps
module ioc_index_io_asserts
   import ioc_pkg::*;
#(
   parameter int IDX_W = 6,
   parameter int OVR_W = 8
)(
   // APB
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic              pready,
   // Motion side
   input wire logic              start_pulse_o,
   input wire ioc_jog_in_t       jog_in,
   input wire logic              jog_fwd_o,
   input wire logic              jog_rev_o,
   input wire logic              soft_limit_en_o,
   input wire logic [OVR_W-1:0]  vel_override_in,
   input wire logic [OVR_W-1:0]  vel_override_o,
   input wire logic              index_reg_absolute_in,
   input wire logic              reg_absolute_o,
   input wire ioc_home_in_t      home_in,
   input wire logic              origin_reached_output,
   input wire logic              encoder_line_drive_o
);
   // ------------------------------------------------------------
   // Shadow of the behaviour register, taken at the APB write edge
   // ------------------------------------------------------------
   logic [6:0] cfg_r;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cfg_r <= 7'h00;
      else if (psel && penable && pready && pwrite && paddr == ADDR_IO_BEHAV)
         cfg_r <= pwdata[6:0];
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   enc_drive_a: assert property (encoder_line_drive_o)
      else $error("encoder output not line drive");
   // Edges right after a behaviour write are skipped: old and new modes mix there
   jog_fwd_a: assert property ($past(presetn) && $stable(cfg_r) |-> jog_fwd_o ==
      $past(cfg_r[2] ? jog_in.fwd && !jog_in.rev : jog_in.go && !jog_in.dir))
      else $error("forward jog wrong");
   jog_rev_a: assert property ($past(presetn) && $stable(cfg_r) |-> jog_rev_o ==
      $past(cfg_r[2] ? jog_in.rev && !jog_in.fwd : jog_in.go && jog_in.dir))
      else $error("reverse jog wrong");
   jog_limit_a: assert property ((jog_fwd_o || jog_rev_o) && $stable(cfg_r) |->
      soft_limit_en_o == cfg_r[5]) else $error("jog limit wrong");
   ovr_live_a: assert property ($past(presetn) && cfg_r[3] && $stable(cfg_r) |->
      vel_override_o == $past(vel_override_in)) else $error("override not live");
   ovr_hold_a: assert property ($past(presetn) && !cfg_r[3] && $stable(cfg_r) &&
      !start_pulse_o |-> $stable(vel_override_o)) else $error("override moved mid index");
   reg_mode_a: assert property ($past(presetn) && !cfg_r[4] && $stable(cfg_r) |->
      reg_absolute_o == $past(index_reg_absolute_in)) else $error("registration type");
   org_set_a: assert property (home_in.homing_done |=> origin_reached_output)
      else $error("origin not set");
   org_drop_a: assert property (cfg_r[6] && !home_in.servo_on && !home_in.homing_done
      |=> !origin_reached_output) else $error("origin not dropped");
endmodule : ioc_index_io_asserts

bind ioc_index_io ioc_index_io_asserts #(.IDX_W(IDX_W), .OVR_W(OVR_W)) ioc_index_io_asserts_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .start_pulse_o(start_pulse_o),
   .jog_in(jog_in), .jog_fwd_o(jog_fwd_o), .jog_rev_o(jog_rev_o),
   .soft_limit_en_o(soft_limit_en_o), .vel_override_in(vel_override_in),
   .vel_override_o(vel_override_o), .index_reg_absolute_in(index_reg_absolute_in),
   .reg_absolute_o(reg_absolute_o), .home_in(home_in),
   .origin_reached_output(origin_reached_output),
   .encoder_line_drive_o(encoder_line_drive_o));

// ---- sim/ioc_index_io_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(g, e) \
   begin \
      comparisons++; \
      if ((g) !== (e)) \
      begin \
         err_total++; \
         $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); \
      end \
   end
module ioc_index_io_tb_top;
   import ioc_pkg::*;
   typedef struct {logic [15:0] a; logic [15:0] rst; logic [31:0] wd; logic [31:0] rb;} ioc_row_t;
   logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [15:0]  paddr;
   logic [31:0]  pwdata, prdata, rd;
   logic         start_in, index_done_in, start_pulse_o, jog_fwd_o, jog_rev_o;
   logic [5:0]   index_select_inputs, start_index_o, index_number_outputs;
   logic         soft_limit_en_o, registration_trigger, index_reg_absolute_in;
   logic         reg_capture_o, reg_absolute_o, origin_reached_output, encoder_line_drive_o;
   logic [7:0]   vel_override_in, vel_override_o;
   ioc_jog_in_t  jog_in;
   ioc_home_in_t home_in;
   int           err_total, comparisons, npulse, ncyc, n0;
   ioc_row_t     rows [5] = '{
      '{ADDR_ENC_STYLE, 16'h0000, 32'hFFFF0001, 32'h00000001},
      '{ADDR_START_SEL, 16'h0000, 32'h00000040, 32'h00000040},
      '{ADDR_START_BUF, 16'h0001, 32'h00000000, 32'h00000000},
      '{ADDR_IO_BEHAV,  16'h0000, 32'h0000007F, 32'h0000007F},
      '{ADDR_REG_CFG,   16'h0000, 32'hA5A50001, 32'h00000001}};

   ioc_index_io ioc_index_io_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .start_in(start_in), .index_select_inputs(index_select_inputs),
      .index_done_in(index_done_in), .start_pulse_o(start_pulse_o),
      .start_index_o(start_index_o), .index_number_outputs(index_number_outputs),
      .jog_in(jog_in), .jog_fwd_o(jog_fwd_o), .jog_rev_o(jog_rev_o),
      .soft_limit_en_o(soft_limit_en_o), .vel_override_in(vel_override_in),
      .vel_override_o(vel_override_o), .registration_trigger(registration_trigger),
      .index_reg_absolute_in(index_reg_absolute_in), .reg_capture_o(reg_capture_o),
      .reg_absolute_o(reg_absolute_o), .home_in(home_in),
      .origin_reached_output(origin_reached_output),
      .encoder_line_drive_o(encoder_line_drive_o));
   ioc_ctrl_model ioc_ctrl_model_i (
      .pclk(pclk), .start_in(start_in), .index_select_inputs(index_select_inputs));

   initial pclk = 1'b0;
   always #2.5 pclk = ~pclk;

   // ------------------------------------------------------------
   // Bus and handshake tasks
   // ------------------------------------------------------------
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc

   task automatic done;
      @(posedge pclk);
      index_done_in <= 1'b1;
      @(posedge pclk);
      index_done_in <= 1'b0;
   endtask : done

   task automatic wpulse;
      int k = 0;
      @(posedge pclk);
      while (start_pulse_o !== 1'b1 && k < 20)
      begin
         @(posedge pclk);
         k++;
      end
      `CHK(start_pulse_o, 1'b1)
   endtask : wpulse

   task automatic wrap_up;
      $display("err_total %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : wrap_up

   // Pulse count and hang guard
   always @(posedge pclk)
   begin
      ncyc++;
      if (start_pulse_o === 1'b1)
         npulse++;
      if (ncyc == 20000)
      begin
         err_total++;
         wrap_up();
      end
   end

   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {index_done_in, registration_trigger, index_reg_absolute_in} = '0;
      {jog_in, home_in, vel_override_in} = '0;
      repeat (16) @(posedge pclk);
      `CHK(encoder_line_drive_o, 1'b1)
      presetn <= 1'b1;
      foreach (rows[r])
      begin
         apb(1'b0, rows[r].a, 32'h0);
         `CHK(rd, {16'h0000, rows[r].rst})
         apb(1'b1, rows[r].a, rows[r].wd);
         apb(1'b0, rows[r].a, 32'h0);
         `CHK(rd, rows[r].rb)
      end
      `CHK(encoder_line_drive_o, 1'b1)
      apb(1'b0, 16'h0000, 32'h0);
      `CHK({err, rd}, {1'b1, 32'h0})
      // Boundary index from the parameter, then a falling edge in rise-only mode
      apb(1'b1, ADDR_IO_BEHAV, 32'h0);
      apb(1'b1, ADDR_START_BUF, 32'h1);
      apb(1'b1, ADDR_START_SEL, 32'd63);
      ioc_ctrl_model_i.toggle(0);
      wpulse();
      `CHK(start_index_o, 6'h3F)
      cyc(2);
      `CHK(index_number_outputs, 6'h3F)
      done();
      cyc(3);
      ioc_ctrl_model_i.toggle(0);
      cyc(6);
      `CHK(npulse, 1)
      // Index from the select pins, outputs show the previous index while running
      apb(1'b1, ADDR_START_SEL, 32'd64);
      apb(1'b1, ADDR_IO_BEHAV, 32'h1);
      ioc_ctrl_model_i.pick(6'h2A);
      ioc_ctrl_model_i.toggle(0);
      wpulse();
      `CHK(start_index_o, 6'h2A)
      cyc(2);
      `CHK(index_number_outputs, 6'h3F)
      done();
      cyc(3);
      `CHK(index_number_outputs, 6'h2A)
      // Both edges count; extra starts beyond the depth are dropped
      apb(1'b1, ADDR_IO_BEHAV, 32'h2);
      ioc_ctrl_model_i.pick(6'h15);
      for (int d = 0; d < 2; d++)
      begin
         apb(1'b1, ADDR_START_BUF, 32'(d));
         n0 = npulse;
         ioc_ctrl_model_i.toggle(0);
         repeat (3) ioc_ctrl_model_i.toggle(3);
         repeat (3)
         begin
            done();
            cyc(4);
         end
         `CHK(npulse - n0, 3 - d)
      end
      // Override live, then held until the next index starts
      apb(1'b1, ADDR_IO_BEHAV, 32'hA);
      @(posedge pclk) vel_override_in <= 8'h5A;
      cyc(3);
      `CHK(vel_override_o, 8'h5A)
      apb(1'b1, ADDR_IO_BEHAV, 32'h2);
      @(posedge pclk) vel_override_in <= 8'hB3;
      cyc(3);
      `CHK(vel_override_o, 8'h5A)
      ioc_ctrl_model_i.toggle(0);
      wpulse();
      `CHK(start_index_o, 6'h15)
      cyc(1);
      `CHK(vel_override_o, 8'hB3)
      done();
      // Jog styles and the jog software limit
      apb(1'b1, ADDR_IO_BEHAV, 32'h0);
      @(posedge pclk) jog_in <= 4'b1000;
      cyc(3);
      `CHK({jog_fwd_o, jog_rev_o, soft_limit_en_o}, 3'b100)
      @(posedge pclk) jog_in <= 4'b1100;
      cyc(3);
      `CHK({jog_fwd_o, jog_rev_o}, 2'b01)
      apb(1'b1, ADDR_IO_BEHAV, 32'h24);
      @(posedge pclk) jog_in <= 4'b0001;
      cyc(3);
      `CHK({jog_fwd_o, jog_rev_o, soft_limit_en_o}, 3'b011)
      @(posedge pclk) jog_in <= 4'b0011;
      cyc(3);
      `CHK({jog_fwd_o, jog_rev_o}, 2'b00)
      // Registration type, then the configured mode
      @(posedge pclk) index_reg_absolute_in <= 1'b1;
      cyc(3);
      `CHK(reg_absolute_o, 1'b1)
      apb(1'b1, ADDR_IO_BEHAV, 32'h10);
      apb(1'b1, ADDR_REG_CFG, 32'h0);
      cyc(2);
      `CHK(reg_absolute_o, 1'b0)
      apb(1'b1, ADDR_REG_CFG, 32'h1);
      cyc(2);
      `CHK(reg_absolute_o, 1'b1)
      @(posedge pclk) registration_trigger <= 1'b1;
      cyc(2);
      `CHK(reg_capture_o, 1'b1)
      cyc(1);
      `CHK(reg_capture_o, 1'b0)
      // Origin kept after servo off, then dropped when so configured
      for (int m = 0; m < 2; m++)
      begin
         apb(1'b1, ADDR_IO_BEHAV, 32'(m * 64));
         @(posedge pclk) home_in <= 3'b011;
         @(posedge pclk) home_in <= 3'b001;
         cyc(2);
         `CHK(origin_reached_output, 1'b1)
         @(posedge pclk) home_in <= 3'b000;
         cyc(3);
         `CHK(origin_reached_output, 1'(1 - m))
      end
      // Homing start clears the origin output while the servo stays on
      @(posedge pclk) home_in <= 3'b011;
      @(posedge pclk) home_in <= 3'b101;
      cyc(2);
      `CHK(origin_reached_output, 1'b0)
      // Reset in mid-run restores outputs and registers
      @(posedge pclk) presetn <= 1'b0;
      cyc(2);
      `CHK({soft_limit_en_o, encoder_line_drive_o, index_number_outputs}, 8'hC0)
      presetn <= 1'b1;
      apb(1'b0, ADDR_START_BUF, 32'h0);
      `CHK(rd, 32'h0000_0001)
      apb(1'b0, ADDR_START_SEL, 32'h0);
      `CHK(rd, 32'h0000_0000)
      wrap_up();
   end
endmodule : ioc_index_io_tb_top
